// File: core/prr_router.v
/*
  remappable peripheral pin router: per-input pin select, per-pin
  output select, pin ownership priority, mapping lock.
  assumes peripheral and pin signals synchronous to clk; fixed-pin
  modules (i2c, analog) are not routed here and arrive as claims.
*/
`include "prr_consts.vh"
module prr_router (
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire key_wr,
  input wire [7:0] key_data,
  input wire lock_wr,
  input wire lock_data,
  input wire in_sel_wr,
  input wire [2:0] in_sel_idx,
  input wire [3:0] in_sel_data,
  input wire out_sel_wr,
  input wire [2:0] out_sel_idx,
  input wire [3:0] out_sel_data,
  input wire [7:0] periph_in_idle,
  input wire [7:0] periph_out,
  input wire [7:0] periph_out_en,
  input wire [7:0] pin_in,
  input wire [7:0] pin_analog,
  input wire [7:0] gpio_out,
  input wire [7:0] gpio_oe,
  input wire [7:0] fixed_out,
  input wire [7:0] fixed_oe,
  output reg [7:0] periph_in_r,
  output reg [7:0] pin_out_r,
  output reg [7:0] pin_oe_r,
  output reg lock_r,
  output reg [7:0] in_sel_legal_r
);
  // unlock window and gated write strobes
  wire unlock_open;
  wire lock_we;
  wire in_sel_we;
  wire out_sel_we;
  // select storage and routing values
  reg [3:0] in_sel_r [0:7];
  reg [3:0] out_sel_r [0:7];
  reg [7:0] periph_in_nxt;
  reg [7:0] pin_out_nxt;
  reg [7:0] pin_oe_nxt;
  reg [7:0] legal_nxt;
  reg [7:0] remap_oe;
  reg [7:0] remap_out;
  integer i;
  integer j;
  integer k;
  integer m;
  integer n;

  // true for a select code that names a pin
  function sel_legal;
    input [3:0] code;
    begin
      sel_legal = (code <= `PRR_SEL_LEGAL_MAX);
    end
  endfunction

  // one bit of an eight-bit vector by code
  function pick_bit;
    input [7:0] vec;
    input [3:0] code;
    begin
      pick_bit = vec[code[2:0]];
    end
  endfunction

  // pin owner priority, returns drive enable then value
  function [1:0] pin_pick;
    input analog;
    input remap_en;
    input remap_val;
    input fixed_en;
    input fixed_val;
    input gpio_en;
    input gpio_val;
    begin
      if (analog)
        pin_pick = 2'b00;
      else if (remap_en)
        pin_pick = {1'b1, remap_val};
      else if (fixed_en)
        pin_pick = {1'b1, fixed_val};
      else
        pin_pick = {gpio_en, gpio_val};
    end
  endfunction

  prr_unlock u_unlock (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .key_wr(key_wr),
    .key_data(key_data),
    .lock_wr(lock_wr),
    .open(unlock_open)
  );

  // write strobes gated by clock enable, lock and window
  assign lock_we = clk_en && lock_wr && unlock_open;
  assign in_sel_we = clk_en && in_sel_wr && !lock_r;
  assign out_sel_we = clk_en && out_sel_wr && !lock_r;

  // lock bit, changes only inside unlock window
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      lock_r <= 1'b0;
    else if (lock_we)
      lock_r <= lock_data;
  end

  // input selects, one per peripheral input
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < `PRR_NUM_IN; k = k + 1) begin
        in_sel_r[k] <= `PRR_SEL_RESET;
      end
    end else if (in_sel_we) begin
      in_sel_r[in_sel_idx] <= in_sel_data;
    end
  end

  // output selects, one per pin
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (m = 0; m < `PRR_NUM_PINS; m = m + 1) begin
        out_sel_r[m] <= `PRR_OUT_RESET;
      end
    end else if (out_sel_we) begin
      out_sel_r[out_sel_idx] <= out_sel_data;
    end
  end

  // input routing per peripheral input
  always @* begin
    periph_in_nxt = periph_in_idle;
    for (i = 0; i < `PRR_NUM_IN; i = i + 1) begin
      if (sel_legal(in_sel_r[i])) begin
        periph_in_nxt[i] = pick_bit(pin_in, in_sel_r[i]);
      end
    end
  end

  // legal select flags
  always @* begin
    legal_nxt = 8'h00;
    for (n = 0; n < `PRR_NUM_IN; n = n + 1) begin
      legal_nxt[n] = sel_legal(in_sel_r[n]);
    end
  end

  // output routing and ownership per pin
  always @* begin
    remap_oe = 8'h00;
    remap_out = 8'h00;
    pin_out_nxt = 8'h00;
    pin_oe_nxt = 8'h00;
    for (j = 0; j < `PRR_NUM_PINS; j = j + 1) begin
      remap_oe[j] = sel_legal(out_sel_r[j]) &&
        pick_bit(periph_out_en, out_sel_r[j]);
      remap_out[j] = pick_bit(periph_out, out_sel_r[j]);
      {pin_oe_nxt[j], pin_out_nxt[j]} = pin_pick(pin_analog[j],
        remap_oe[j], remap_out[j], fixed_oe[j], fixed_out[j],
        gpio_oe[j], gpio_out[j]);
    end
  end

  // routed peripheral inputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      periph_in_r <= 8'h00;
    else if (clk_en)
      periph_in_r <= periph_in_nxt;
  end

  // pin drive values
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      pin_out_r <= 8'h00;
    else if (clk_en)
      pin_out_r <= pin_out_nxt;
  end

  // pin drive enables
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      pin_oe_r <= 8'h00;
    else if (clk_en)
      pin_oe_r <= pin_oe_nxt;
  end

  // legal select flags, registered
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      in_sel_legal_r <= 8'h00;
    else if (clk_en)
      in_sel_legal_r <= legal_nxt;
  end
endmodule

// File: core/prr_consts.vh
/*
  constants for the remappable peripheral pin router.
  assumes inclusion by bare name from core design files.
*/
`ifndef PRR_CONSTS_VH
`define PRR_CONSTS_VH
`define PRR_NUM_PINS 8
`define PRR_NUM_IN 8
`define PRR_NUM_OUT 8
`define PRR_SEL_W 4
`define PRR_SEL_LEGAL_MAX 4'h7
`define PRR_SEL_RESET 4'hF
`define PRR_OUT_RESET 4'hF
`define PRR_KEY1 8'hAA
`define PRR_KEY2 8'h55
`define PRR_ST_IDLE 2'h0
`define PRR_ST_KEY1 2'h1
`define PRR_ST_OPEN 2'h2
`endif

// File: core/prr_unlock.v
/*
  unlock sequence tracker: two key writes in a row open a one-shot
  window for a single lock change.
  assumes key strobes are synchronous to clk.
*/
`include "prr_consts.vh"
module prr_unlock (
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire key_wr,
  input wire [7:0] key_data,
  input wire lock_wr,
  output wire open
);
  localparam ST_IDLE = `PRR_ST_IDLE;
  localparam ST_KEY1 = `PRR_ST_KEY1;
  localparam ST_OPEN = `PRR_ST_OPEN;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  assign open = (state_r == ST_OPEN);
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (key_wr && key_data == `PRR_KEY1)
          state_nxt = ST_KEY1;
      end
      ST_KEY1: begin
        if (key_wr && key_data == `PRR_KEY2)
          state_nxt = ST_OPEN;
        else if (key_wr || lock_wr)
          state_nxt = ST_IDLE;
      end
      ST_OPEN: begin
        if (lock_wr || key_wr)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end
endmodule

// File: dv/prr_pads.sv
/* pad model: pull-up on every remappable pin.
   assumes router pin drive outputs. */
module prr_pads (
  input [7:0] pin_out_r,
  input [7:0] pin_oe_r,
  output [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_in = pin_out_r & pin_oe_r | ~pin_oe_r;
endmodule

// File: dv/prr_router_assertions.sv
/* router checker on top ports.
   assumes bind from bench top, one clock. */
module prr_router_assertions (
  input clk, reset_n, clk_en, lock_wr, lock_data, in_sel_wr, lock_r,
  input [2:0] in_sel_idx,
  input [3:0] in_sel_data,
  input [7:0] periph_in_idle, periph_out_en, pin_analog, gpio_oe,
  input [7:0] fixed_oe, periph_in_r, pin_oe_r, in_sel_legal_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_lock_by_write: assert property ($changed(lock_r) |->
    $past(lock_wr) && lock_r == $past(lock_data)) else $error("lock");
  a_reset_unmapped: assert property ($rose(reset_n) |=>
    in_sel_legal_r == 0) else $error("mapped after reset");
  a_idle_unmapped: assert property (clk_en |=>
    ((periph_in_r ^ $past(periph_in_idle)) & ~in_sel_legal_r) == 0)
    else $error("unmapped input not idle");
  a_code_legal: assert property (clk_en && in_sel_wr && !lock_r ##1
    clk_en |=> in_sel_legal_r[$past(in_sel_idx, 2)] ==
    ($past(in_sel_data, 2) < 4'h8)) else $error("legal flag");
  a_locked_keep: assert property (lock_r && in_sel_wr ##1 lock_r |=>
    $stable(in_sel_legal_r)) else $error("select moved while locked");
  a_analog_wins: assert property (clk_en |=>
    (pin_oe_r & $past(pin_analog)) == 0) else $error("analog pin driven");
  a_fixed_oe: assert property (clk_en && periph_out_en == 0 |=>
    pin_oe_r == (($past(fixed_oe) | $past(gpio_oe)) & ~$past(pin_analog)))
    else $error("pin drive wrong");
  a_lock_hold: assert property (!lock_wr |=> $stable(lock_r))
    else $error("lock moved");
endmodule

// File: dv/test_remappable_peripheral_pin_router.sv
/* router bench: random and corner cases, self checking.
   assumes pad model and bound checker. */
module test_remappable_peripheral_pin_router;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, key_wr = 0, lock_wr = 0, lock_data = 0;
  logic clk_en = 1, in_sel_wr = 0, out_sel_wr = 0, lock_r;
  logic [2:0] in_sel_idx = 0, out_sel_idx = 0;
  logic [3:0] in_sel_data = 0, out_sel_data = 0;
  logic [7:0] key_data = 0, periph_in_idle = 0, periph_out = 0;
  logic [7:0] periph_out_en = 0, pin_analog = 0, gpio_out = 0;
  logic [7:0] gpio_oe = 0, fixed_out = 0, fixed_oe = 0, pin_in;
  logic [7:0] periph_in_r, pin_out_r, pin_oe_r, in_sel_legal_r;
  int errors = 0, checked = 0, c, i;
  always #50 clk = ~clk;
  prr_router uut (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .key_wr(key_wr),
    .key_data(key_data),
    .lock_wr(lock_wr),
    .lock_data(lock_data),
    .in_sel_wr(in_sel_wr),
    .in_sel_idx(in_sel_idx),
    .in_sel_data(in_sel_data),
    .out_sel_wr(out_sel_wr),
    .out_sel_idx(out_sel_idx),
    .out_sel_data(out_sel_data),
    .periph_in_idle(periph_in_idle),
    .periph_out(periph_out),
    .periph_out_en(periph_out_en),
    .pin_in(pin_in),
    .pin_analog(pin_analog),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .fixed_out(fixed_out),
    .fixed_oe(fixed_oe),
    .periph_in_r(periph_in_r),
    .pin_out_r(pin_out_r),
    .pin_oe_r(pin_oe_r),
    .lock_r(lock_r),
    .in_sel_legal_r(in_sel_legal_r)
  );
  prr_pads pads (
    .pin_out_r(pin_out_r),
    .pin_oe_r(pin_oe_r),
    .pin_in(pin_in)
  );
  function automatic logic exp_route(int code, int idx);
    if (code < 8)
      return gpio_out[code] | ~gpio_oe[code];
    return periph_in_idle[idx];
  endfunction
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic op(int k, int x, logic [7:0] d);
    @(posedge clk);
    {key_wr, lock_wr, in_sel_wr, out_sel_wr} <= 4'h8 >> k;
    key_data <= d;
    lock_data <= d[0];
    {in_sel_idx, out_sel_idx} <= {x[2:0], x[2:0]};
    {in_sel_data, out_sel_data} <= {d[3:0], d[3:0]};
    @(posedge clk);
    {key_wr, lock_wr, in_sel_wr, out_sel_wr} <= 4'h0;
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clk);
    errors++;
    conclude;
  end
  initial begin
    void'($urandom(32'hD0E030EB));
    repeat (2) @(posedge clk);
    reset_n <= 1;
    periph_in_idle <= $urandom;
    gpio_out <= $urandom;
    gpio_oe <= $urandom;
    for (c = 0; c < 16; c++) begin
      i = $urandom % 8;
      op(2, i, c);
      settle(3);
      cmp("route", exp_route(c, i), periph_in_r[i]);
      cmp("legal", c < 8, in_sel_legal_r[i]);
    end
    @(posedge clk);
    fixed_oe <= 8'hFF;
    fixed_out <= $urandom;
    periph_out <= $urandom;
    periph_out_en <= 8'hFF;
    c = $urandom % 8;
    op(3, i, c);
    settle(3);
    cmp("remap", periph_out[c], pin_out_r[i]);
    cmp("fixed", fixed_out[(i + 1) % 8], pin_out_r[(i + 1) % 8]);
    @(posedge clk);
    pin_analog <= 8'hFF;
    settle(2);
    cmp("analog", 8'h00, pin_oe_r);
    op(2, 0, 3);
    op(1, 0, 1);
    settle(2);
    cmp("lock", 0, lock_r);
    op(0, 0, 8'hAA);
    op(0, 0, 8'h55);
    op(1, 0, 1);
    op(2, 0, 9);
    settle(3);
    cmp("lock", 1, lock_r);
    cmp("kept", 1, in_sel_legal_r[0]);
    conclude;
  end
endmodule
bind prr_router prr_router_assertions chk (
  .clk(clk),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .lock_wr(lock_wr),
  .lock_data(lock_data),
  .in_sel_wr(in_sel_wr),
  .lock_r(lock_r),
  .in_sel_idx(in_sel_idx),
  .in_sel_data(in_sel_data),
  .periph_in_idle(periph_in_idle),
  .periph_out_en(periph_out_en),
  .pin_analog(pin_analog),
  .gpio_oe(gpio_oe),
  .fixed_oe(fixed_oe),
  .periph_in_r(periph_in_r),
  .pin_oe_r(pin_oe_r),
  .in_sel_legal_r(in_sel_legal_r)
);
